// ---- design/pcf_plane_control.sv ----
/*
 * Format field group of a plane control register: software copy, armed double buffer,
 * active copy, surface update timing and the per-pixel key qualifiers.
 * Assumes every input other than the asynchronous reset rst_b is synchronous to clk and that software keeps the programming limits.
 */
`timescale 1ns/1ps
module pcf_plane_control
    import pcf_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic           ctl_wr,
    input  wire logic [31:0]    ctl_wdata,
    output logic [31:0]         ctl_rdata,
    input  wire logic           surf_wr,
    input  wire logic           cs_flip,
    input  wire logic [2:0]     cs_tiling,
    input  wire logic           plane_enabled,
    input  wire logic           pipe_enabled,
    input  wire logic           vblank_start,
    input  wire logic [2:0]     plane_index,
    input  wire pcf_fmt_type    format_class,
    input  wire logic           key_match,
    input  wire logic           upper_opaque,
    input  wire logic           lower_opaque,
    output pcf_fields_type      active,
    output logic                async_mode,
    output logic                surf_apply,
    output logic                eff_bgr_order,
    output logic                eff_luma,
    output logic                component_illegal,
    output logic [1:0]          eff_yuv_order,
    output logic                decomp_on,
    output logic                clear_colour_on,
    output logic                upper_as_opaque,
    output logic                this_transparent
);
    // ============================================================
    // Double-buffered fields; the async bit takes effect at once
    pcf_fields_type soft_copy;
    pcf_fields_type next_soft_copy;
    pcf_fields_type next_active;
    logic           armed;
    logic           next_armed;
    logic           next_async_mode;
    logic           surf_pending;
    logic           next_surf_pending;
    logic           next_surf_apply;
    logic           transfer;
    logic           arm_event;

    assign arm_event = surf_wr | cs_flip | ~plane_enabled;
    assign transfer  = armed & (vblank_start | ~pipe_enabled);

    always_comb begin
        next_soft_copy  = soft_copy;
        next_async_mode = async_mode;
        if (ctl_wr) begin
            next_soft_copy.key_mode   = ctl_wdata[KEY_LSB +: 2];
            next_soft_copy.bgr_order  = ctl_wdata[ORDER_BIT];
            next_soft_copy.luma_sel   = ctl_wdata[COMP_BIT];
            next_soft_copy.yuv_order  = ctl_wdata[YUV_LSB +: 2];
            next_soft_copy.decomp     = ctl_wdata[DECOMP_BIT];
            next_soft_copy.cc_disable = ctl_wdata[CCD_BIT];
            next_soft_copy.tiling     = ctl_wdata[TILE_LSB +: 3];
            next_async_mode           = ctl_wdata[ASYNC_BIT];
        end
        // Sync flip carries its own tiling and arms like a surface write
        if (cs_flip) begin
            next_soft_copy.tiling = cs_tiling;
        end
        // Arming wins over the clear done by a transfer in the same cycle
        next_armed  = arm_event | (armed & ~transfer);
        next_active = transfer ? soft_copy : active;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_copy  <= FIELDS_RESET;
            active     <= FIELDS_RESET;
            armed      <= 1'b0;
            async_mode <= 1'b0;
        end else begin
            soft_copy  <= next_soft_copy;
            active     <= next_active;
            armed      <= next_armed;
            async_mode <= next_async_mode;
        end
    end

    // ============================================================
    // Surface address update timing
    always_comb begin
        next_surf_apply   = 1'b0;
        next_surf_pending = surf_pending;
        if (surf_wr && async_mode) begin
            next_surf_apply = 1'b1;
        end else if (surf_wr) begin
            next_surf_pending = 1'b1;
        end
        if (surf_pending && (vblank_start || !pipe_enabled)) begin
            next_surf_apply   = 1'b1;
            next_surf_pending = surf_wr & ~async_mode;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            surf_pending <= 1'b0;
            surf_apply   <= 1'b0;
        end else begin
            surf_pending <= next_surf_pending;
            surf_apply   <= next_surf_apply;
        end
    end

    // ============================================================
    // Readback: reserved bits and bits outside this group stay zero
    always_comb begin
        ctl_rdata = 32'h0;
        ctl_rdata[KEY_LSB +: 2]  = soft_copy.key_mode;
        ctl_rdata[ORDER_BIT]     = soft_copy.bgr_order;
        ctl_rdata[COMP_BIT]      = soft_copy.luma_sel;
        ctl_rdata[YUV_LSB +: 2]  = soft_copy.yuv_order;
        ctl_rdata[DECOMP_BIT]    = soft_copy.decomp;
        ctl_rdata[CCD_BIT]       = soft_copy.cc_disable;
        ctl_rdata[TILE_LSB +: 3] = soft_copy.tiling;
        ctl_rdata[ASYNC_BIT]     = async_mode;
        ctl_rdata[RSV_HI]        = 1'b0;
        ctl_rdata[RSV_LO]        = 1'b0;
    end

    // ============================================================
    // Effective controls and key qualifiers, registered
    logic       next_bgr;
    logic       next_luma;
    logic       next_comp_illegal;
    logic [1:0] next_yuv;
    logic       next_decomp;
    logic       next_cc;
    logic       next_upper;
    logic       next_transp;
    logic       y_capable;

    assign y_capable = (plane_index >= PLANE_Y_FIRST) && (plane_index <= PLANE_Y_LAST);

    always_comb begin
        next_bgr          = active.bgr_order & (format_class == PCF_FMT_RGB);
        // Luma only where planar and the plane may carry it; wrong pairing is flagged
        next_luma         = active.luma_sel & (format_class == PCF_FMT_PLANAR) & y_capable;
        next_comp_illegal = (format_class == PCF_FMT_PLANAR) ? (active.luma_sel != y_capable)
                                                             : active.luma_sel;
        next_yuv          = (format_class == PCF_FMT_YUV422_8) ? active.yuv_order : 2'h0;
        next_decomp       = active.decomp;
        next_cc           = active.decomp & ~active.cc_disable;
        next_upper        = upper_opaque;
        next_transp       = 1'b0;
        unique case (active.key_mode)
            KEY_OFF: begin
            end
            KEY_SRC: begin
                next_transp = key_match;
            end
            KEY_DST: begin
                next_upper = key_match & upper_opaque;
            end
            KEY_SRC_WIN: begin
                next_transp = key_match & lower_opaque;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            eff_bgr_order     <= 1'b0;
            eff_luma          <= 1'b0;
            component_illegal <= 1'b0;
            eff_yuv_order     <= 2'h0;
            decomp_on         <= 1'b0;
            clear_colour_on   <= 1'b0;
            upper_as_opaque   <= 1'b0;
            this_transparent  <= 1'b0;
        end else begin
            eff_bgr_order     <= next_bgr;
            eff_luma          <= next_luma;
            component_illegal <= next_comp_illegal;
            eff_yuv_order     <= next_yuv;
            decomp_on         <= next_decomp;
            clear_colour_on   <= next_cc;
            upper_as_opaque   <= next_upper;
            this_transparent  <= next_transp;
        end
    end

    // ============================================================
    // Assertions
    dst_key_blend_a: assert property (@(posedge clk) disable iff (!rst_b)
        (active.key_mode == KEY_DST) |=> (upper_as_opaque == ($past(key_match) && $past(upper_opaque))))
        else $error("destination key opacity wrong");
    src_window_a: assert property (@(posedge clk) disable iff (!rst_b)
        (active.key_mode == KEY_SRC_WIN) |=> (this_transparent == ($past(key_match) && $past(lower_opaque))))
        else $error("source key window transparency wrong");
    colour_order_a: assert property (@(posedge clk) disable iff (!rst_b)
        (format_class != PCF_FMT_RGB) |=> !eff_bgr_order)
        else $error("colour order not ignored");
    component_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
        (format_class != PCF_FMT_PLANAR) |=> !eff_luma)
        else $error("luma selected on non-planar format");
    byte_order_a: assert property (@(posedge clk) disable iff (!rst_b)
        (format_class == PCF_FMT_YUV422_8) |=> (eff_yuv_order == $past(active.yuv_order)))
        else $error("byte order not followed");
    decomp_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> (decomp_on == $past(active.decomp)))
        else $error("decompression enable not followed");
    clear_colour_a: assert property (@(posedge clk) disable iff (!rst_b)
        clear_colour_on |-> decomp_on && !$past(active.cc_disable))
        else $error("clear colour on without decompression");
    tiling_flip_a: assert property (@(posedge clk) disable iff (!rst_b)
        (cs_flip && !ctl_wr) ##1 (vblank_start && pipe_enabled && plane_enabled) |=> (active.tiling == $past(cs_tiling, 2)))
        else $error("sync flip tiling not applied");
    async_apply_a: assert property (@(posedge clk) disable iff (!rst_b)
        (surf_wr && async_mode) |=> surf_apply)
        else $error("async surface update not immediate");
    sync_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (surf_wr && !async_mode && !surf_pending && pipe_enabled) ##1 (!vblank_start && pipe_enabled) |=> !surf_apply)
        else $error("sync surface update before vblank");
    no_arm_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!armed && !transfer) |=> $stable(active))
        else $error("active copy changed while unarmed");
    pipe_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        (armed && !pipe_enabled) |=> (active == $past(soft_copy)))
        else $error("pipe off did not transfer fields");
    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        !ctl_rdata[RSV_HI] && !ctl_rdata[RSV_LO])
        else $error("reserved bit reads nonzero");
endmodule

// ---- inc/pcf_pkg.sv ----
/*
 * Package for the plane control format field group: field positions, reset values,
 * key modes, format classes and the field carrier struct.
 * Assumes a single 32-bit plane control word, the bits outside this group being held elsewhere.
 */
package pcf_pkg;
    // ============================================================
    // Field positions within the plane control word
    localparam int KEY_LSB   = 21;
    localparam int ORDER_BIT = 20;
    localparam int COMP_BIT  = 19;
    localparam int RSV_HI    = 18;
    localparam int YUV_LSB   = 16;
    localparam int DECOMP_BIT = 15;
    localparam int RSV_LO    = 14;
    localparam int CCD_BIT   = 13;
    localparam int TILE_LSB  = 10;
    localparam int ASYNC_BIT = 9;

    // ============================================================
    // Encodings and reset values
    localparam logic [1:0] KEY_OFF      = 2'h0;
    localparam logic [1:0] KEY_SRC      = 2'h1;
    localparam logic [1:0] KEY_DST      = 2'h2;
    localparam logic [1:0] KEY_SRC_WIN  = 2'h3;
    localparam logic [2:0] TILE_LINEAR  = 3'h0;
    localparam logic [2:0] TILE_X       = 3'h1;
    localparam logic [2:0] TILE_Y       = 3'h4;
    localparam logic [2:0] PLANE_UV_LAST = 3'h3;
    localparam logic [2:0] PLANE_Y_FIRST = 3'h4;
    localparam logic [2:0] PLANE_Y_LAST  = 3'h5;

    typedef enum logic [2:0] {
        PCF_FMT_RGB,
        PCF_FMT_RGB_BIASED,
        PCF_FMT_RGB565,
        PCF_FMT_YUV422_8,
        PCF_FMT_PLANAR,
        PCF_FMT_OTHER
    } pcf_fmt_type;

    typedef struct packed {
        logic [1:0] key_mode;
        logic       bgr_order;
        logic       luma_sel;
        logic [1:0] yuv_order;
        logic       decomp;
        logic       cc_disable;
        logic [2:0] tiling;
    } pcf_fields_type;

    localparam pcf_fields_type FIELDS_RESET = '{KEY_OFF, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, TILE_LINEAR};
endpackage

// ---- verification/pcf_testbench.sv ----
/*
 * Self-checking bench for the plane control format field group: register access,
 * double buffering, surface timing, effective controls and per-pixel key qualifiers.
 * Assumes pcf_pkg is compiled first; the bench drives every port itself.
 */
`timescale 1ns/1ps
module testbench;
    import pcf_pkg::*;
    // ============================================================
    // Stimulus and observed signals
    logic           clk = 1'b0;
    logic           rst_b = 1'b0;
    logic           ctl_wr = 1'b0;
    logic [31:0]    ctl_wdata = 32'h0;
    logic           surf_wr = 1'b0;
    logic           cs_flip = 1'b0;
    logic [2:0]     cs_tiling = 3'h0;
    logic           plane_enabled = 1'b1;
    logic           pipe_enabled = 1'b1;
    logic           vblank_start = 1'b0;
    logic [2:0]     plane_index = 3'h1;
    pcf_fmt_type    format_class = PCF_FMT_RGB;
    logic           key_match = 1'b0;
    logic           upper_opaque = 1'b0;
    logic           lower_opaque = 1'b0;
    logic [31:0]    ctl_rdata;
    pcf_fields_type active;
    logic           async_mode, surf_apply, eff_bgr_order, eff_luma, component_illegal;
    logic [1:0]     eff_yuv_order;
    logic           decomp_on, clear_colour_on, upper_as_opaque, this_transparent;
    int             err_total = 0;
    int             compares = 0;
    logic           m, u, l;
    localparam logic [31:0] TILED_Y_WORD = 32'(TILE_Y) << TILE_LSB;

    always #25 clk = ~clk;

    pcf_plane_control uut (
        .clk(clk), .rst_b(rst_b), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
        .surf_wr(surf_wr), .cs_flip(cs_flip), .cs_tiling(cs_tiling), .plane_enabled(plane_enabled),
        .pipe_enabled(pipe_enabled), .vblank_start(vblank_start), .plane_index(plane_index),
        .format_class(format_class), .key_match(key_match), .upper_opaque(upper_opaque),
        .lower_opaque(lower_opaque), .active(active), .async_mode(async_mode), .surf_apply(surf_apply),
        .eff_bgr_order(eff_bgr_order), .eff_luma(eff_luma), .component_illegal(component_illegal),
        .eff_yuv_order(eff_yuv_order), .decomp_on(decomp_on), .clear_colour_on(clear_colour_on),
        .upper_as_opaque(upper_as_opaque), .this_transparent(this_transparent)
    );

    // ============================================================
    // Access tasks
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Pulses last one cycle and end on a falling edge, so back-to-back calls never collide
    task automatic wr(input logic [31:0] d);
        @(negedge clk);
        ctl_wr = 1'b1;
        ctl_wdata = d;
        @(negedge clk);
        ctl_wr = 1'b0;
    endtask

    task automatic surf();
        @(negedge clk);
        surf_wr = 1'b1;
        @(negedge clk);
        surf_wr = 1'b0;
    endtask

    task automatic vbl();
        @(negedge clk);
        vblank_start = 1'b1;
        @(negedge clk);
        vblank_start = 1'b0;
    endtask

    // Full arm and transfer, then two more cycles for the effective outputs
    task automatic load(input logic [31:0] d);
        wr(d);
        surf();
        vbl();
        cyc(2);
    endtask

    task automatic ld_eff(input logic [31:0] d, input logic [2:0] p, input pcf_fmt_type f, input logic [3:0] e);
        plane_index = p;
        format_class = f;
        load(d);
        chk("eff_luma", eff_luma, e[3]);
        chk("component_illegal", component_illegal, e[2]);
        chk("decomp_on", decomp_on, e[1]);
        chk("clear_colour_on", clear_colour_on, e[0]);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        cyc(8);
        rst_b = 1'b1;
        chk("rdata reset", ctl_rdata, 32'h0);
        chk("active reset", active, 32'h0);
        // Fields first with async clear, so no async flip ever carries field changes
        wr(32'hfffffdff);
        chk("rdata mask", ctl_rdata, 32'h007bbc00);
        chk("async off", async_mode, 32'h0);
        chk("active before arm", active, 32'h0);
        vbl();
        cyc(1);
        chk("vblank unarmed", active, 32'h0);
        // Sync surface writes wait for vertical blank
        surf();
        chk("sync held", surf_apply, 32'h0);
        cyc(1);
        chk("sync pending", surf_apply, 32'h0);
        vbl();
        chk("sync apply", surf_apply, 32'h1);
        chk("armed transfer", active, 32'h7ff);
        cyc(1);
        chk("apply single", surf_apply, 32'h0);
        // Async bit alone, then a single surface write and back to sync
        wr(32'hffffffff);
        chk("rdata async", ctl_rdata, 32'h007bbe00);
        chk("async immediate", async_mode, 32'h1);
        surf();
        chk("async apply", surf_apply, 32'h1);
        cyc(1);
        chk("async single", surf_apply, 32'h0);
        wr(32'h0);
        chk("async cleared", async_mode, 32'h0);
        // Key qualifiers for every mode and every input combination
        for (int k = 0; k < 4; k++) begin
            // One RGB plane of a single pair, never indexed; no plane gamma in this block
            load(32'(k) << KEY_LSB);
            for (int i = 0; i < 8; i++) begin
                @(negedge clk);
                {m, u, l} = 3'(i);
                {key_match, upper_opaque, lower_opaque} = {m, u, l};
                @(negedge clk);
                chk("upper_as_opaque", upper_as_opaque, (k == 2) ? (m & u) : u);
                chk("this_transparent", this_transparent, (k == 1) ? m : ((k == 3) ? (m & l) : 1'b0));
            end
        end
        load(32'h1 << ORDER_BIT);
        for (int f = 0; f < 4; f++) begin
            format_class = pcf_fmt_type'(f);
            cyc(2);
            chk("eff_bgr_order", eff_bgr_order, (f == 0) ? 32'h1 : 32'h0);
        end
        for (int y = 0; y < 4; y++) begin
            load(32'(y) << YUV_LSB);
            chk("eff_yuv_order", eff_yuv_order, 32'(y));
        end
        ld_eff(32'h1 << COMP_BIT, 3'h4, PCF_FMT_PLANAR, 4'h8);
        ld_eff(32'h1 << COMP_BIT, 3'h2, PCF_FMT_PLANAR, 4'h4);
        ld_eff(32'h0, 3'h2, PCF_FMT_PLANAR, 4'h0);
        ld_eff(32'h0, 3'h5, PCF_FMT_PLANAR, 4'h4);
        ld_eff(32'h1 << COMP_BIT, 3'h3, PCF_FMT_RGB, 4'h4);
        // Decompression only on Y-tiled RGB; clear colour value taken as loaded beforehand
        ld_eff((32'h1 << DECOMP_BIT) | TILED_Y_WORD, 3'h1, PCF_FMT_RGB, 4'h3);
        ld_eff((32'h1 << DECOMP_BIT) | (32'h1 << CCD_BIT) | TILED_Y_WORD, 3'h1, PCF_FMT_RGB, 4'h2);
        ld_eff(32'h1 << CCD_BIT, 3'h1, PCF_FMT_RGB, 4'h0);
        // Tiling by register write, then by a command-streamer flip
        load(32'(TILE_X) << TILE_LSB);
        chk("tiling write", active.tiling, TILE_X);
        // Flips only while async is off, and only to supported tilings
        @(negedge clk);
        cs_flip = 1'b1;
        cs_tiling = TILE_Y;
        @(negedge clk);
        cs_flip = 1'b0;
        cyc(1);
        chk("flip readback", ctl_rdata[TILE_LSB +: 3], TILE_Y);
        vbl();
        chk("flip transfer", active.tiling, TILE_Y);
        // Flip followed at once by vertical blank
        @(negedge clk);
        cs_flip = 1'b1;
        cs_tiling = TILE_X;
        @(negedge clk);
        cs_flip = 1'b0;
        vblank_start = 1'b1;
        @(negedge clk);
        vblank_start = 1'b0;
        chk("flip then vblank", active.tiling, TILE_X);
        // Plane off arms and pipe off transfers without a vertical blank
        wr(32'(KEY_DST) << KEY_LSB);
        @(negedge clk);
        plane_enabled = 1'b0;
        pipe_enabled = 1'b0;
        cyc(3);
        chk("pipe off transfer", active.key_mode, KEY_DST);
        plane_enabled = 1'b1;
        pipe_enabled = 1'b1;
        cyc(2);
        results();
    end
endmodule
